// [rtl/cblu_cfg.svh]
// constants of the conditional branch and loop unit
`ifndef CBLU_CFG_SVH
`define CBLU_CFG_SVH

// datapath widths
`define CBLU_IP_W          32
`define CBLU_CNT_W         32
`define CBLU_CNT16_W       16
`define CBLU_CC_W          4

// reset values
`define CBLU_IP_RST        32'h0000_0000
`define CBLU_CNT_RST       32'h0000_0000

// condition codes; each alias spelling shares one code
`define CBLU_CC_OVF        4'h0
`define CBLU_CC_NO_OVF     4'h1
`define CBLU_CC_BELOW      4'h2
`define CBLU_CC_ABOVE_EQ   4'h3
`define CBLU_CC_EQUAL      4'h4
`define CBLU_CC_NOT_EQUAL  4'h5
`define CBLU_CC_BELOW_EQ   4'h6
`define CBLU_CC_ABOVE      4'h7
`define CBLU_CC_SIGN       4'h8
`define CBLU_CC_NO_SIGN    4'h9
`define CBLU_CC_PAR_EVEN   4'ha
`define CBLU_CC_PAR_ODD    4'hb
`define CBLU_CC_LESS       4'hc
`define CBLU_CC_GREATER_EQ 4'hd
`define CBLU_CC_LESS_EQ    4'he
`define CBLU_CC_GREATER    4'hf
`define CBLU_CC_CARRY      `CBLU_CC_BELOW
`define CBLU_CC_NO_CARRY   `CBLU_CC_ABOVE_EQ

// cycles from the taking edge to the answer
`define CBLU_RESOLVE_CYC   2

`endif

// [rtl/cblu_pkg.sv]
// types of the conditional branch and loop unit
`include "cblu_cfg.svh"
package cblu_pkg;

   typedef enum logic [2:0]
   {
      CBLU_OP_JUMP_CC,
      CBLU_OP_JUMP_IF_COUNT_ZERO,
      CBLU_OP_LOOP,
      CBLU_OP_LOOP_WHILE_EQUAL,
      CBLU_OP_LOOP_WHILE_NOT_EQUAL
   } cblu_op_t;

   typedef enum logic [1:0]
   {
      CBLU_ST_IDLE,
      CBLU_ST_RESOLVE
   } cblu_state_t;

   typedef struct packed
   {
      logic carry_flag;
      logic parity_flag;
      logic zero_flag;
      logic sign_flag;
      logic overflow_flag;
   } cblu_flags_t;

   typedef struct packed
   {
      cblu_op_t                op;
      logic [`CBLU_CC_W-1:0]   cc;
      cblu_flags_t             flags;
      logic                    addr16;
      logic [`CBLU_CNT_W-1:0]  count;
      logic [`CBLU_IP_W-1:0]   ip_next;
      logic [`CBLU_IP_W-1:0]   disp;
   } cblu_req_t;

   typedef struct packed
   {
      logic                    taken;
      logic [`CBLU_IP_W-1:0]   next_ip;
      logic                    count_we;
      logic [`CBLU_CNT_W-1:0]  count;
   } cblu_res_t;

endpackage

// [rtl/cblu_cond_eval.sv]
// condition code evaluator for conditional near jumps
`timescale 1ns/1ns
`default_nettype none
`include "cblu_cfg.svh"
module cblu_cond_eval
(
   // condition selector and status flags
   input  wire logic [`CBLU_CC_W-1:0] cc_in,
   input  wire cblu_pkg::cblu_flags_t flags_in,
   // evaluation result
   output var  logic                  true_out
);
   import cblu_pkg::*;

   logic lt;
   logic le;
   logic be;

   always_comb
   begin
      lt = flags_in.sign_flag ^ flags_in.overflow_flag; // RL8
      le = lt | flags_in.zero_flag; // RL7
      be = flags_in.carry_flag | flags_in.zero_flag; // RL5
      // one code per condition, so alias spellings cannot diverge
      case (cc_in) // RL10
         `CBLU_CC_OVF:        true_out = flags_in.overflow_flag; // RL9
         `CBLU_CC_NO_OVF:     true_out = !flags_in.overflow_flag; // RL9
         `CBLU_CC_BELOW:      true_out = flags_in.carry_flag; // RL6
         `CBLU_CC_ABOVE_EQ:   true_out = !flags_in.carry_flag; // RL6
         `CBLU_CC_EQUAL:      true_out = flags_in.zero_flag; // RL9
         `CBLU_CC_NOT_EQUAL:  true_out = !flags_in.zero_flag; // RL9
         `CBLU_CC_BELOW_EQ:   true_out = be; // RL5
         `CBLU_CC_ABOVE:      true_out = !be; // RL5
         `CBLU_CC_SIGN:       true_out = flags_in.sign_flag; // RL9
         `CBLU_CC_NO_SIGN:    true_out = !flags_in.sign_flag; // RL9
         `CBLU_CC_PAR_EVEN:   true_out = flags_in.parity_flag; // RL9
         `CBLU_CC_PAR_ODD:    true_out = !flags_in.parity_flag; // RL9
         `CBLU_CC_LESS:       true_out = lt; // RL8
         `CBLU_CC_GREATER_EQ: true_out = !lt; // RL8
         `CBLU_CC_LESS_EQ:    true_out = le; // RL7
         default:             true_out = !le; // RL7
      endcase
   end

endmodule
`default_nettype wire

// [rtl/cblu_top.sv]
// conditional branch and loop resolution unit, top level
`timescale 1ns/1ns
`default_nettype none
`include "cblu_cfg.svh"
// Overview of operation
// RL1 - false condition falls through to next instruction, true redirects to target
// RL2 - taken conditional jump saves no return pointer
// RL3 - target is signed displacement from instruction pointer, same code segment
// RL4 - conditional jumps are near only; code segment never changes
// RL5 - above true when carry or zero is 0; below-equal when 1
// RL6 - above-equal and no-carry on carry 0; below and carry on 1
// RL7 - greater when (sign xor overflow) or zero is 0; less-equal when 1
// RL8 - greater-equal when sign xor overflow is 0; less when 1
// RL9 - single-flag conditions test zero, parity, overflow or sign directly
// RL10 - alias spellings decode to one identical condition
// RL11 - count-zero jumps test the count register, not the flags
// RL12 - 32-bit count-zero jump branches exactly when full count is zero
// RL13 - under 16-bit addressing only the low 16 count bits are tested
// RL14 - loops decrement count first, low 16 bits under 16-bit addressing
// RL15 - loop falls through when decremented count reaches zero
// RL16 - loop starting at count zero wraps to all ones and keeps going
// RL17 - loop-while-equal branches on nonzero count and zero flag set
// RL18 - loop-while-not-equal branches on nonzero count and zero flag clear
// RL19 - destination is next instruction pointer plus sign-extended displacement
module cblu_top
(
   // clock, reset, enable
   input  wire logic                clk_in,
   input  wire logic                rst_in,
   input  wire logic                ce_in,
   // request from decode
   input  wire logic                req_valid_in,
   input  wire cblu_pkg::cblu_req_t req_in,
   output var  logic                ready_out,
   // resolution to fetch and count register
   output var  logic                done_out,
   output var  cblu_pkg::cblu_res_t res_out
);
   import cblu_pkg::*;

   cblu_state_t             state_reg;
   cblu_state_t             state_next;
   cblu_req_t               req_reg;
   cblu_res_t               res_next;
   logic                    cc_true;
   logic [`CBLU_CNT_W-1:0]  cnt_dec;
   logic [`CBLU_IP_W-1:0]   target;
   logic                    take_req;

   function automatic logic op_is_loop(input cblu_op_t op);
      op_is_loop = (op == CBLU_OP_LOOP) ||
                   (op == CBLU_OP_LOOP_WHILE_EQUAL) ||
                   (op == CBLU_OP_LOOP_WHILE_NOT_EQUAL);
   endfunction

   // zero test on the width that the address size selects
   function automatic logic cnt_is_zero(input logic [`CBLU_CNT_W-1:0] val,
                                        input logic                   addr16);
      if (addr16)
         cnt_is_zero = (val[`CBLU_CNT16_W-1:0] == 16'h0000); // RL13
      else
         cnt_is_zero = (val == 32'h0000_0000); // RL12
   endfunction

   assign take_req = req_valid_in && ready_out;

   cblu_cond_eval u_cond
   (
      .cc_in    (req_reg.cc),
      .flags_in (req_reg.flags),
      .true_out (cc_true)
   );

   // sequencing
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         CBLU_ST_IDLE:
         begin
            if (take_req)
               state_next = CBLU_ST_RESOLVE;
         end
         CBLU_ST_RESOLVE:
         begin
            state_next = CBLU_ST_IDLE;
         end
         default:
         begin
            state_next = CBLU_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         state_reg <= CBLU_ST_IDLE;
         ready_out <= 1'b0;
      end
      else if (ce_in)
      begin
         state_reg <= state_next;
         ready_out <= (state_next == CBLU_ST_IDLE);
      end
   end

   // request held until the next one is taken
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         req_reg.op      <= CBLU_OP_JUMP_CC;
         req_reg.cc      <= `CBLU_CC_OVF;
         req_reg.flags   <= '0;
         req_reg.addr16  <= 1'b0;
         req_reg.count   <= `CBLU_CNT_RST;
         req_reg.ip_next <= `CBLU_IP_RST;
         req_reg.disp    <= `CBLU_IP_RST;
      end
      else if (ce_in && take_req)
      begin
         req_reg <= req_in;
      end
   end

   // count decrement and branch arithmetic
   always_comb
   begin
      cnt_dec = req_reg.count - 32'h0000_0001; // RL14 RL16
      if (req_reg.addr16)
      begin
         // upper half of the count survives a 16-bit loop
         cnt_dec = {req_reg.count[`CBLU_CNT_W-1:`CBLU_CNT16_W],
                    req_reg.count[`CBLU_CNT16_W-1:0] - 16'h0001}; // RL14
      end
      // displacement arrives sign-extended; wrap stays inside the segment
      target = req_reg.ip_next + req_reg.disp; // RL3 RL19
   end

   // branch decision; only the offset changes, never the segment
   always_comb
   begin
      res_next.count_we = op_is_loop(req_reg.op);
      res_next.count    = req_reg.count;
      if (op_is_loop(req_reg.op))
         res_next.count = cnt_dec; // RL14
      case (req_reg.op)
         CBLU_OP_JUMP_CC:
         begin
            res_next.taken = cc_true; // RL1
         end
         CBLU_OP_JUMP_IF_COUNT_ZERO:
         begin
            res_next.taken = cnt_is_zero(req_reg.count, req_reg.addr16); // RL11
         end
         CBLU_OP_LOOP:
         begin
            res_next.taken = !cnt_is_zero(cnt_dec, req_reg.addr16); // RL15
         end
         CBLU_OP_LOOP_WHILE_EQUAL:
         begin
            res_next.taken = !cnt_is_zero(cnt_dec, req_reg.addr16) &&
                             req_reg.flags.zero_flag; // RL17
         end
         CBLU_OP_LOOP_WHILE_NOT_EQUAL:
         begin
            res_next.taken = !cnt_is_zero(cnt_dec, req_reg.addr16) &&
                             !req_reg.flags.zero_flag; // RL18
         end
         default:
         begin
            res_next.taken = 1'b0;
         end
      endcase
      // one-way transfer: no return pointer leaves this unit
      res_next.next_ip = res_next.taken ? target : req_reg.ip_next; // RL1 RL2 RL4
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         done_out         <= 1'b0;
         res_out.taken    <= 1'b0;
         res_out.next_ip  <= `CBLU_IP_RST;
         res_out.count_we <= 1'b0;
         res_out.count    <= `CBLU_CNT_RST;
      end
      else if (ce_in)
      begin
         done_out <= (state_reg == CBLU_ST_RESOLVE);
         if (state_reg == CBLU_ST_RESOLVE)
            res_out <= res_next;
      end
   end

   // checks; a frozen enable stalls the sequence, so it pauses them
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in || !ce_in);

   sequence s_take;
      req_valid_in && ready_out;
   endsequence

   sequence s_resolve;
      !ready_out ##1 done_out;
   endsequence

   sequence s_done_op(cblu_op_t op);
      done_out && (req_reg.op == op);
   endsequence

   sequence s_done_cc(logic [3:0] cc);
      done_out && (req_reg.op == CBLU_OP_JUMP_CC) && (req_reg.cc == cc);
   endsequence

   answer_latency_a: assert property (s_take |=> s_resolve)
      else $error("answer not two cycles after request");

   done_pulse_a: assert property (done_out |=> !done_out)
      else $error("done stood longer than one cycle");

   ready_with_done_a: assert property (done_out |-> ready_out)
      else $error("ready low while answer stands");

   fall_through_a: assert property (s_take ##2 (done_out && !res_out.taken) // RL1
      |-> res_out.next_ip == req_reg.ip_next)
      else $error("fall-through pointer wrong");

   branch_target_a: assert property (done_out && res_out.taken // RL19
      |-> res_out.next_ip == req_reg.ip_next + req_reg.disp)
      else $error("taken target wrong");

   jump_no_count_a: assert property (done_out && !op_is_loop(req_reg.op) // RL2
      |-> !res_out.count_we)
      else $error("jump wrote count register");

   above_cond_a: assert property (s_done_cc(`CBLU_CC_ABOVE) // RL5
      |-> res_out.taken == !(req_reg.flags.carry_flag | req_reg.flags.zero_flag))
      else $error("above condition wrong");

   below_eq_cond_a: assert property (s_done_cc(`CBLU_CC_BELOW_EQ) // RL5
      |-> res_out.taken == (req_reg.flags.carry_flag | req_reg.flags.zero_flag))
      else $error("below-equal condition wrong");

   carry_cond_a: assert property (s_done_cc(`CBLU_CC_CARRY) // RL6
      |-> res_out.taken == req_reg.flags.carry_flag)
      else $error("carry condition wrong");

   no_carry_cond_a: assert property (s_done_cc(`CBLU_CC_NO_CARRY) // RL6 RL10
      |-> res_out.taken == !req_reg.flags.carry_flag)
      else $error("no-carry condition wrong");

   greater_cond_a: assert property (s_done_cc(`CBLU_CC_GREATER) // RL7
      |-> res_out.taken == !((req_reg.flags.sign_flag ^ req_reg.flags.overflow_flag)
                             | req_reg.flags.zero_flag))
      else $error("greater condition wrong");

   less_eq_cond_a: assert property (s_done_cc(`CBLU_CC_LESS_EQ) // RL7
      |-> res_out.taken == ((req_reg.flags.sign_flag ^ req_reg.flags.overflow_flag)
                            | req_reg.flags.zero_flag))
      else $error("less-equal condition wrong");

   less_cond_a: assert property (s_done_cc(`CBLU_CC_LESS) // RL8
      |-> res_out.taken == (req_reg.flags.sign_flag ^ req_reg.flags.overflow_flag))
      else $error("less condition wrong");

   greater_eq_cond_a: assert property (s_done_cc(`CBLU_CC_GREATER_EQ) // RL8
      |-> res_out.taken == !(req_reg.flags.sign_flag ^ req_reg.flags.overflow_flag))
      else $error("greater-equal condition wrong");

   equal_cond_a: assert property (s_done_cc(`CBLU_CC_EQUAL) // RL9
      |-> res_out.taken == req_reg.flags.zero_flag)
      else $error("equal condition wrong");

   not_equal_cond_a: assert property (s_done_cc(`CBLU_CC_NOT_EQUAL) // RL9
      |-> res_out.taken == !req_reg.flags.zero_flag)
      else $error("not-equal condition wrong");

   sign_cond_a: assert property (s_done_cc(`CBLU_CC_SIGN) // RL9
      |-> res_out.taken == req_reg.flags.sign_flag)
      else $error("sign condition wrong");

   overflow_cond_a: assert property (s_done_cc(`CBLU_CC_OVF) // RL9
      |-> res_out.taken == req_reg.flags.overflow_flag)
      else $error("overflow condition wrong");

   parity_cond_a: assert property (s_done_cc(`CBLU_CC_PAR_ODD) // RL9
      |-> res_out.taken == !req_reg.flags.parity_flag)
      else $error("parity condition wrong");

   count32_zero_a: assert property (s_done_op(CBLU_OP_JUMP_IF_COUNT_ZERO) // RL12
      && !req_reg.addr16
      |-> res_out.taken == (req_reg.count == 32'h0000_0000))
      else $error("32-bit count-zero jump wrong");

   count16_zero_a: assert property (s_done_op(CBLU_OP_JUMP_IF_COUNT_ZERO) // RL13
      && req_reg.addr16
      |-> res_out.taken == (req_reg.count[15:0] == 16'h0000))
      else $error("16-bit count-zero jump wrong");

   loop_decrement_a: assert property (done_out && op_is_loop(req_reg.op) // RL14
      && !req_reg.addr16
      |-> res_out.count_we && (res_out.count == req_reg.count - 32'h0000_0001))
      else $error("loop decrement wrong");

   loop16_upper_a: assert property (done_out && op_is_loop(req_reg.op) && req_reg.addr16 // RL14
      |-> res_out.count[31:16] == req_reg.count[31:16])
      else $error("16-bit loop touched upper count");

   loop16_lower_a: assert property (done_out && op_is_loop(req_reg.op) && req_reg.addr16 // RL14
      |-> res_out.count_we && (res_out.count[15:0] == req_reg.count[15:0] - 16'h0001))
      else $error("16-bit loop decrement wrong");

   loop_wrap_a: assert property (s_done_op(CBLU_OP_LOOP) && !req_reg.addr16 // RL16
      && (req_reg.count == 32'h0000_0000)
      |-> res_out.taken && (res_out.count == 32'hffff_ffff))
      else $error("loop from zero did not wrap");

   loop16_wrap_a: assert property (s_done_op(CBLU_OP_LOOP) && req_reg.addr16 // RL16
      && (req_reg.count[15:0] == 16'h0000)
      |-> res_out.taken && (res_out.count[15:0] == 16'hffff))
      else $error("16-bit loop from zero did not wrap");

   loop_exit_a: assert property (s_done_op(CBLU_OP_LOOP) && !req_reg.addr16 // RL15
      && (req_reg.count == 32'h0000_0001)
      |-> !res_out.taken && (res_out.next_ip == req_reg.ip_next))
      else $error("loop did not end at zero");

   loop16_exit_a: assert property (s_done_op(CBLU_OP_LOOP) && req_reg.addr16 // RL15
      && (req_reg.count[15:0] == 16'h0001)
      |-> !res_out.taken && (res_out.next_ip == req_reg.ip_next))
      else $error("16-bit loop did not end at zero");

   loop_equal_a: assert property (s_done_op(CBLU_OP_LOOP_WHILE_EQUAL) // RL17
      |-> res_out.taken == (req_reg.flags.zero_flag && (req_reg.addr16 ?
          (req_reg.count[15:0] != 16'h0001) : (req_reg.count != 32'h0000_0001))))
      else $error("loop-while-equal wrong");

   loop_not_equal_a: assert property (s_done_op(CBLU_OP_LOOP_WHILE_NOT_EQUAL) // RL18
      && req_reg.flags.zero_flag |-> !res_out.taken)
      else $error("loop-while-not-equal ran on zero flag");

   loop_ne_run_a: assert property (s_done_op(CBLU_OP_LOOP_WHILE_NOT_EQUAL) // RL18
      && !req_reg.flags.zero_flag && !req_reg.addr16 && (req_reg.count != 32'h0000_0001)
      |-> res_out.taken)
      else $error("loop-while-not-equal stopped early");

endmodule
`default_nettype wire

// [dv/test_cblu_top.sv]
// self-checking bench for the conditional branch and loop unit
`timescale 1ns/1ns
`default_nettype none
`include "cblu_cfg.svh"
module test_cblu_top;
   import cblu_pkg::*;

   // design ports
   logic      clk_in       = 1'b0;
   logic      rst_in       = 1'b1;
   logic      ce_in        = 1'b1;
   logic      req_valid_in = 1'b0;
   cblu_req_t req_in       = '0;
   logic      ready_out;
   logic      done_out;
   cblu_res_t res_out;
   // bookkeeping
   int        num_errors   = 0;
   int        cmp_count    = 0;

   always #25 clk_in = ~clk_in;

   cblu_top i_dut
   (
      .clk_in       (clk_in),
      .rst_in       (rst_in),
      .ce_in        (ce_in),
      .req_valid_in (req_valid_in),
      .req_in       (req_in),
      .ready_out    (ready_out),
      .done_out     (done_out),
      .res_out      (res_out)
   );

   task automatic print_verdict();
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic fail(input string msg);
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask

   task automatic expect_bit(input logic got, input logic want, input string what);
      cmp_count++;
      if (got !== want)
         fail($sformatf("%s is %b", what, got));
   endtask

   // one request; stall freezes ce_in for that many cycles after the take
   task automatic issue(input cblu_op_t op, input logic [3:0] cc, input logic [4:0] fl,
                        input logic a16, input logic [31:0] cnt, input logic [31:0] ip,
                        input logic [31:0] disp, input int stall);
      int n;
      n = 0;
      while (ready_out !== 1'b1)
      begin
         if (n == 20)
         begin
            fail("ready never rose");
            print_verdict();
         end
         n++;
         @(posedge clk_in);
         #5;
      end
      req_valid_in = 1'b1;
      req_in = '{op, cc, cblu_flags_t'(fl), a16, cnt, ip, disp};
      @(posedge clk_in);
      #5;
      req_valid_in = 1'b0;
      req_in = ~req_in;
      expect_bit(ready_out, 1'b0, "ready after take");
      expect_bit(done_out, 1'b0, "done one edge early");
      if (stall > 0)
      begin
         ce_in = 1'b0;
         for (int i = 0; i < stall; i++)
         begin
            @(posedge clk_in);
            #5;
            expect_bit(done_out, 1'b0, "done while frozen");
            expect_bit(ready_out, 1'b0, "ready while frozen");
         end
         ce_in = 1'b1;
      end
      // answer stands in the cycle after the second enabled edge
      @(posedge clk_in);
      #5;
      expect_bit(done_out, 1'b1, "done two edges after take");
      expect_bit(ready_out, 1'b1, "ready with done");
   endtask

   task automatic chk(input logic t, input logic [31:0] ip, input logic we,
                      input logic [31:0] c);
      cmp_count++;
      if (res_out !== {t, ip, we, c})
         fail($sformatf("result %h, expected %h", res_out, {t, ip, we, c}));
   endtask

   // even codes test the plain condition, odd codes its inverse
   function automatic logic cond(input logic [3:0] cc, input logic [4:0] f);
      logic c, p, z, s, o, t;
      {c, p, z, s, o} = f;
      case (cc[3:1])
         3'h0:    t = o;
         3'h1:    t = c;
         3'h2:    t = z;
         3'h3:    t = c | z;
         3'h4:    t = s;
         3'h5:    t = p;
         3'h6:    t = s ^ o;
         default: t = (s ^ o) | z;
      endcase
      return t ^ cc[0];
   endfunction

   // every code against every flag pattern
   task automatic test_jcc();
      logic t;
      for (int cc = 0; cc < 16; cc++)
      begin
         for (int f = 0; f < 32; f++)
         begin
            t = cond(cc[3:0], f[4:0]);
            issue(CBLU_OP_JUMP_CC, cc[3:0], f[4:0], 1'b0, 32'h0000_0007,
                  32'h0000_4000, 32'h0000_0100, 0);
            chk(t, t ? 32'h0000_4100 : 32'h0000_4000, 1'b0, 32'h0000_0007);
         end
      end
      issue(CBLU_OP_JUMP_CC, `CBLU_CC_CARRY, 5'h10, 1'b0, 32'h0, 32'h0000_4000,
            32'h0000_0100, 0);
      chk(1'b1, 32'h0000_4100, 1'b0, 32'h0);
      issue(CBLU_OP_JUMP_CC, `CBLU_CC_NO_CARRY, 5'h10, 1'b0, 32'h0, 32'h0000_4000,
            32'h0000_0100, 0);
      chk(1'b0, 32'h0000_4000, 1'b0, 32'h0);
   endtask

   // backward and wrapping targets, one with a frozen clock enable
   task automatic test_target();
      issue(CBLU_OP_JUMP_CC, `CBLU_CC_ABOVE_EQ, 5'h00, 1'b0, 32'h0, 32'h0000_0010,
            32'hffff_fff0, 3);
      chk(1'b1, 32'h0000_0000, 1'b0, 32'h0);
      issue(CBLU_OP_JUMP_CC, `CBLU_CC_ABOVE_EQ, 5'h00, 1'b1, 32'h0, 32'hffff_fff8,
            32'h0000_0010, 0);
      chk(1'b1, 32'h0000_0008, 1'b0, 32'h0);
   endtask

   // ip 0x100, displacement 0x20; count written back only by loops
   task automatic row(input cblu_op_t op, input logic [4:0] fl, input logic a16,
                      input logic [31:0] c, input logic t, input logic [31:0] ec);
      issue(op, 4'h0, fl, a16, c, 32'h0000_0100, 32'h0000_0020, 0);
      chk(t, t ? 32'h0000_0120 : 32'h0000_0100, op != CBLU_OP_JUMP_IF_COUNT_ZERO, ec);
   endtask

   // flags set opposite to any flag reading, to show they are ignored
   task automatic test_count_zero();
      row(CBLU_OP_JUMP_IF_COUNT_ZERO, 5'h00, 1'b0, 32'h0000_0000, 1'b1, 32'h0000_0000);
      row(CBLU_OP_JUMP_IF_COUNT_ZERO, 5'h1f, 1'b0, 32'h0001_0000, 1'b0, 32'h0001_0000);
      row(CBLU_OP_JUMP_IF_COUNT_ZERO, 5'h1f, 1'b0, 32'h8000_0000, 1'b0, 32'h8000_0000);
      row(CBLU_OP_JUMP_IF_COUNT_ZERO, 5'h00, 1'b1, 32'h0001_0000, 1'b1, 32'h0001_0000);
      row(CBLU_OP_JUMP_IF_COUNT_ZERO, 5'h1f, 1'b1, 32'h0000_0001, 1'b0, 32'h0000_0001);
   endtask

   task automatic test_loop();
      row(CBLU_OP_LOOP, 5'h00, 1'b0, 32'h0000_0001, 1'b0, 32'h0000_0000);
      row(CBLU_OP_LOOP, 5'h1f, 1'b0, 32'h0000_0002, 1'b1, 32'h0000_0001);
      row(CBLU_OP_LOOP, 5'h00, 1'b0, 32'h0000_0000, 1'b1, 32'hffff_ffff);
      row(CBLU_OP_LOOP, 5'h00, 1'b1, 32'h1234_0000, 1'b1, 32'h1234_ffff);
      row(CBLU_OP_LOOP, 5'h00, 1'b1, 32'h0005_0001, 1'b0, 32'h0005_0000);
   endtask

   // zero flag is bit 2 of the flag pattern
   task automatic test_loop_zf();
      row(CBLU_OP_LOOP_WHILE_EQUAL, 5'h1f, 1'b0, 32'h0000_0002, 1'b1, 32'h0000_0001);
      row(CBLU_OP_LOOP_WHILE_EQUAL, 5'h1b, 1'b0, 32'h0000_0002, 1'b0, 32'h0000_0001);
      row(CBLU_OP_LOOP_WHILE_EQUAL, 5'h1f, 1'b0, 32'h0000_0001, 1'b0, 32'h0000_0000);
      row(CBLU_OP_LOOP_WHILE_NOT_EQUAL, 5'h1b, 1'b0, 32'h0000_0002, 1'b1, 32'h0000_0001);
      row(CBLU_OP_LOOP_WHILE_NOT_EQUAL, 5'h1f, 1'b0, 32'h0000_0002, 1'b0, 32'h0000_0001);
      row(CBLU_OP_LOOP_WHILE_NOT_EQUAL, 5'h1b, 1'b1, 32'h0003_0001, 1'b0, 32'h0003_0000);
   endtask

   // mid-run reset clears the answer, then the handshake restarts
   task automatic test_reset();
      rst_in = 1'b1;
      @(posedge clk_in);
      #5;
      chk(1'b0, 32'h0000_0000, 1'b0, 32'h0000_0000);
      expect_bit(ready_out, 1'b0, "ready in mid-run reset");
      expect_bit(done_out, 1'b0, "done in mid-run reset");
      rst_in = 1'b0;
      @(posedge clk_in);
      #5;
      expect_bit(ready_out, 1'b1, "ready one edge after release");
      expect_bit(done_out, 1'b0, "done one edge after release");
      row(CBLU_OP_LOOP, 5'h00, 1'b1, 32'h0007_0000, 1'b1, 32'h0007_ffff);
   endtask

   initial
   begin
      repeat (16) @(posedge clk_in);
      #5;
      expect_bit(ready_out, 1'b0, "ready in reset");
      expect_bit(done_out, 1'b0, "done in reset");
      rst_in = 1'b0;
      test_jcc();
      test_target();
      test_count_zero();
      test_loop();
      test_loop_zf();
      test_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
